// ===== rtl/pcg_pkg.sv
// Constants shared by the panel CPU bus glue
package pcg_pkg;
	// ************************************
	// Clock and timing
	// ************************************
	localparam int unsigned CLK_MHZ          = 200;
	localparam int unsigned SYS_OSC_HZ       = 7372800;
	localparam int unsigned E_DIV            = 4;
	localparam int unsigned BUS_PHASE_HZ     = SYS_OSC_HZ / E_DIV;
	localparam int unsigned CPU_RST_E_CYC    = 4064;
	localparam int unsigned RST_HOLD_MS      = 50;
	localparam int unsigned RST_HOLD_CYC_DEF = RST_HOLD_MS * CLK_MHZ * 1000;
	localparam int unsigned RST_CNT_W        = 24;
	localparam int unsigned LAMP_HALF_NS     = 40;
	localparam int unsigned LAMP_HALF_CYC    = (LAMP_HALF_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0]  LAMP_HALF        = 4'(LAMP_HALF_CYC - 1);
	localparam logic [2:0]  LAMP_LAST_BIT    = 3'h7;
	// ************************************
	// Bus phases
	// ************************************
	localparam logic [1:0] PH_ADDR0 = 2'h0;
	localparam logic [1:0] PH_DATA0 = 2'h2;
	localparam logic [1:0] PH_DATA1 = 2'h3;
	localparam logic [1:0] PH_STEP  = 2'h1;
	// ************************************
	// Address decode
	// ************************************
	localparam int unsigned A15        = 15;
	localparam int unsigned A14        = 14;
	localparam int unsigned IO_IDX_MSB = 13;
	localparam int unsigned IO_IDX_LSB = 11;
	localparam logic [15:0] RAM_BASE   = 16'h4000;
	localparam logic [15:0] RAM_TOP    = 16'h7FFF;
	localparam logic [15:0] ADDR_IDLE  = 16'hFFFF;
	localparam logic [2:0]  IO_SWITCH_RD_A = 3'h6;
	localparam logic [2:0]  IO_ID_RD_B     = 3'h7;
	localparam logic [7:0]  SEL_NONE   = 8'hFF;
	localparam logic [7:0]  SEL_ONE    = 8'h01;
	// ************************************
	// Register map
	// ************************************
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_LAMP     = 8'h04;
	localparam logic [7:0] REG_EXT_ADDR = 8'h08;
	localparam logic [7:0] REG_EXT_WR   = 8'h0C;
	localparam logic [7:0] REG_EXT_RD   = 8'h10;
	localparam logic [7:0] REG_STATUS   = 8'h14;
	localparam int unsigned CTRL_TX_BIT   = 0;
	localparam int unsigned CTRL_LAMP_LSB = 4;
	localparam int unsigned ST_EXT_BUSY   = 0;
	localparam int unsigned ST_LAMP_BUSY  = 1;
	localparam int unsigned ST_RST_DONE   = 2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'b0;
endpackage

// ===== rtl/pcg_rst_stretch.sv
// Supervisor reset stretcher for the board reset line
`timescale 1ns/100ps
`default_nettype none
module pcg_rst_stretch #(
	parameter int unsigned HOLD_CYC = pcg_pkg::RST_HOLD_CYC_DEF
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Supply monitor and stretched reset
	input  wire logic supply_ok,
	output logic      rst_done
);
	import pcg_pkg::*;
	localparam logic [RST_CNT_W-1:0] LAST = RST_CNT_W'(HOLD_CYC - 1);
	typedef struct packed {
		logic [RST_CNT_W-1:0] cnt;
		logic                 done;
	} pcg_rst_st_t;
	pcg_rst_st_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (!supply_ok) begin
			s_d = '0;
		end else if (!s_q.done) begin
			s_d.cnt  = s_q.cnt + RST_CNT_W'(1);
			s_d.done = (s_q.cnt == LAST);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rst_done = s_q.done;

	rst_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(s_q.done) |-> $past(s_q.cnt) == LAST && $past(supply_ok))
		else $error("board reset released early");
	rst_cov_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(s_q.done));
endmodule
`default_nettype wire

// ===== rtl/pcg_lamp_shift.sv
// Serial bitstream shifter for the lamp drivers
`timescale 1ns/100ps
`default_nettype none
module pcg_lamp_shift (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Byte to send
	input  wire logic       go,
	input  wire logic [7:0] byte_in,
	output logic            busy,
	// Serial lines
	output logic            ser_bit,
	output logic            ser_clk
);
	import pcg_pkg::*;
	typedef struct packed {
		logic [7:0] sh;
		logic [3:0] cnt;
		logic [2:0] idx;
		logic       sclk;
		logic       busy;
	} pcg_lamp_st_t;
	pcg_lamp_st_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (!s_q.busy) begin
			if (go) begin
				s_d      = '0;
				s_d.sh   = byte_in;
				s_d.busy = 1'b1;
			end
		end else if (s_q.cnt != LAMP_HALF) begin
			s_d.cnt = s_q.cnt + 4'h1;
		end else begin
			s_d.cnt  = '0;
			s_d.sclk = !s_q.sclk;
			if (s_q.sclk) begin
				s_d.sh  = {s_q.sh[6:0], 1'b0};
				s_d.idx = s_q.idx + 3'h1;
				s_d.busy = (s_q.idx != LAMP_LAST_BIT);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign busy    = s_q.busy;
	assign ser_bit = s_q.sh[7];
	assign ser_clk = s_q.sclk;

	lamp_setup_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(s_q.sclk) |-> $stable(s_q.sh[7]) ##1 $stable(s_q.sh[7]))
		else $error("lamp bit moved at clock rise");
	lamp_cov_c: cover property (@(posedge clk) disable iff (!rst_n) $fell(s_q.busy));
endmodule
`default_nettype wire

// ===== rtl/pcg_glue.sv
// Panel CPU bus glue: bus cycle engine, decode and board controls
// ************************************
// ************************************
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module pcg_glue #(
	parameter int unsigned RST_HOLD_CYC = pcg_pkg::RST_HOLD_CYC_DEF
) (
	// Clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic             HREADYOUT,
	output logic [31:0]      HRDATA,
	output logic             HRESP,
	// Multiplexed external bus
	output logic [7:0]       EXT_ADDR_HI,
	output logic [7:0]       EXT_ADDR_LO,
	input  wire logic [7:0]  EXT_AD_I,
	output logic [7:0]       EXT_AD_O,
	output logic             EXT_AD_OE_N,
	output logic             ADDR_STROBE,
	output logic             EXT_RD,
	output logic             BUS_PHASE_CLK,
	// Memory and I/O selects
	output logic             RAM_SEL_LO_N,
	output logic             RAM_SEL_HI,
	output logic             RAM_WE_N,
	output logic [7:0]       IO_SEL_N,
	// Switches and board ID
	input  wire logic [9:0]  ADDR_SWITCH_BITS,
	input  wire logic [5:0]  BOARD_ID,
	// Lamp drivers
	output logic             LAMP_SER_BIT,
	output logic             LAMP_SER_CLK,
	output logic [3:0]       LAMP_DRV_SEL_N,
	// Line transceiver and board reset
	output logic             LINE_TX_EN,
	input  wire logic        SUPPLY_OK,
	output logic             SYS_RST_N
);
	import pcg_pkg::*;

	typedef struct packed {
		logic [1:0]  ph;
		logic        strobe;
		logic        pclk;
		logic        act;
		logic        rd;
		logic        pend;
		logic        prd;
		logic [15:0] addr;
		logic [15:0] ext_addr;
		logic [7:0]  wdat;
		logic [7:0]  rdat;
		logic [7:0]  ad_o;
		logic        ad_oe_n;
		logic [7:0]  alo;
		logic        ram_lo_n;
		logic        ram_hi;
		logic        we_n;
		logic [7:0]  sel_n;
		logic        tx_en;
		logic [3:0]  lamp_sel;
		logic        lamp_go;
		logic [7:0]  lamp_byte;
		logic        dph;
		logic        dwr;
		logic        dmap;
		logic [7:0]  daddr;
		logic        hready;
		logic [31:0] hrdata;
	} pcg_glue_st_t;

	localparam pcg_glue_st_t GLUE_RST = '{
		addr: ADDR_IDLE, ad_oe_n: 1'b1, ram_lo_n: 1'b1, we_n: 1'b1,
		sel_n: SEL_NONE, hready: 1'b1, default: '0};

	pcg_glue_st_t s_q, s_d;
	logic         rst_done;
	logic         lamp_busy;
	logic         ext_busy;

	// ************************************
	// Board reset and lamp shifter
	// ************************************
	// stretched supervisor reset
	pcg_rst_stretch #(.HOLD_CYC(RST_HOLD_CYC)) u_rst (
		.clk       (CLOCK),
		.rst_n     (RST_N),
		.supply_ok (SUPPLY_OK),
		.rst_done  (rst_done)
	);

	pcg_lamp_shift u_lamp (
		.clk     (CLOCK),
		.rst_n   (RST_N),
		.go      (s_q.lamp_go),
		.byte_in (s_q.lamp_byte),
		.busy    (lamp_busy),
		.ser_bit (LAMP_SER_BIT),
		.ser_clk (LAMP_SER_CLK)
	);

	assign ext_busy = s_q.pend || s_q.act;

	// ************************************
	// Next state
	// ************************************
	always_comb begin
		s_d         = s_q;
		s_d.lamp_go = 1'b0;
		s_d.ph     = s_q.ph + PH_STEP;
		s_d.strobe = (s_d.ph == PH_ADDR0);
		s_d.pclk   = (s_d.ph == PH_DATA0) || (s_d.ph == PH_DATA1);
		if (s_d.ph == PH_ADDR0) begin
			s_d.act = s_q.pend && rst_done;
			if (s_d.act) begin
				s_d.rd   = s_q.prd;
				s_d.addr = s_q.ext_addr;
				s_d.pend = 1'b0;
			end
		end
		if (s_d.act && !s_d.pclk) begin
			s_d.ad_o    = s_d.addr[7:0];
			s_d.ad_oe_n = 1'b0;
		end else if (s_d.act && !s_d.rd) begin
			s_d.ad_o    = s_q.wdat;
			s_d.ad_oe_n = 1'b0;
		end else begin
			s_d.ad_oe_n = 1'b1;
		end
		if (s_q.strobe && !s_d.strobe) begin
			s_d.alo = s_q.ad_o;
		end
		s_d.ram_lo_n = s_d.addr[A15];
		s_d.ram_hi = s_d.act && s_d.addr[A14] && s_d.pclk;
		s_d.we_n = !(s_d.act && s_d.pclk && !s_d.rd);
		s_d.sel_n = SEL_NONE;
		if (s_d.act && s_d.pclk && !s_d.addr[A15] && !s_d.addr[A14]) begin
			s_d.sel_n = ~(SEL_ONE << s_d.addr[IO_IDX_MSB:IO_IDX_LSB]);
		end
		// Read data taken at end of second half
		if (s_q.ph == PH_DATA1 && s_q.act && s_q.rd) begin
			if (!s_q.sel_n[IO_SWITCH_RD_A]) begin
				s_d.rdat = ADDR_SWITCH_BITS[7:0];
			end else if (!s_q.sel_n[IO_ID_RD_B]) begin
				s_d.rdat = {ADDR_SWITCH_BITS[9:8], BOARD_ID};
			end else begin
				s_d.rdat = EXT_AD_I;
			end
		end
		if (!rst_done) begin
			s_d.tx_en = 1'b0;
		end
		// AHB-Lite address and data phase
		s_d.hready = 1'b1;
		if (s_q.dph) begin
			s_d.dph    = 1'b0;
			s_d.hrdata = '0;
			if (!s_q.dmap) begin
				s_d.hrdata = '0;
			end else if (s_q.daddr == REG_CTRL) begin
				if (s_q.dwr) begin
					s_d.tx_en    = HWDATA[CTRL_TX_BIT] && rst_done;
					s_d.lamp_sel = HWDATA[CTRL_LAMP_LSB +: 4];
				end
				s_d.hrdata[CTRL_TX_BIT]       = s_q.tx_en;
				s_d.hrdata[CTRL_LAMP_LSB +: 4] = s_q.lamp_sel;
			end else if (s_q.daddr == REG_LAMP) begin
				if (s_q.dwr && !lamp_busy) begin
					s_d.lamp_byte = HWDATA[7:0];
					s_d.lamp_go   = 1'b1;
				end
				s_d.hrdata[7:0] = s_q.lamp_byte;
			end else if (s_q.daddr == REG_EXT_ADDR) begin
				if (s_q.dwr) begin
					s_d.ext_addr = HWDATA[15:0];
				end
				s_d.hrdata[15:0] = s_q.ext_addr;
			end else if (s_q.daddr == REG_EXT_WR) begin
				if (s_q.dwr && !ext_busy) begin
					s_d.wdat = HWDATA[7:0];
					s_d.pend = 1'b1;
					s_d.prd  = 1'b0;
				end
				s_d.hrdata[7:0] = s_q.wdat;
			end else if (s_q.daddr == REG_EXT_RD) begin
				if (s_q.dwr && !ext_busy) begin
					s_d.pend = 1'b1;
					s_d.prd  = 1'b1;
				end
				s_d.hrdata[7:0] = s_q.rdat;
			end else if (s_q.daddr == REG_STATUS) begin
				s_d.hrdata[ST_EXT_BUSY]  = ext_busy;
				s_d.hrdata[ST_LAMP_BUSY] = lamp_busy;
				s_d.hrdata[ST_RST_DONE]  = rst_done;
			end
		end else if (HSEL && HREADY && HTRANS == HTRANS_NONSEQ) begin
			s_d.dph    = 1'b1;
			s_d.hready = 1'b0;
			s_d.dwr    = HWRITE;
			s_d.daddr  = HADDR[7:0];
			s_d.dmap   = (HADDR[31:8] == '0) && (HADDR[1:0] == 2'h0);
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			s_q <= GLUE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************
	// Outputs
	// ************************************
	assign HREADYOUT     = s_q.hready;
	assign HRDATA        = s_q.hrdata;
	assign HRESP         = HRESP_OKAY;
	assign EXT_ADDR_HI   = s_q.addr[15:8];
	assign EXT_ADDR_LO   = s_q.alo;
	assign EXT_AD_O      = s_q.ad_o;
	assign EXT_AD_OE_N   = s_q.ad_oe_n;
	assign ADDR_STROBE   = s_q.strobe;
	assign EXT_RD        = s_q.rd || !s_q.act;
	assign BUS_PHASE_CLK = s_q.pclk;
	assign RAM_SEL_LO_N  = s_q.ram_lo_n;
	assign RAM_SEL_HI    = s_q.ram_hi;
	assign RAM_WE_N      = s_q.we_n;
	assign IO_SEL_N      = s_q.sel_n;
	assign LAMP_DRV_SEL_N = ~s_q.lamp_sel;
	assign LINE_TX_EN    = s_q.tx_en;
	assign SYS_RST_N     = rst_done;

	// ************************************
	// Assertions
	// ************************************
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);

	phase_period_a: assert property ($rose(s_q.pclk) |-> ##4 $rose(s_q.pclk))
		else $error("phase clock period not four cycles");
	addr_catch_a: assert property ($fell(s_q.strobe) |-> s_q.alo == $past(s_q.ad_o))
		else $error("low address not captured at strobe fall");
	addr_hold_a: assert property (!$fell(s_q.strobe) |-> $stable(s_q.alo))
		else $error("low address changed between strobes");
	drive_dir_a: assert property (s_q.act && s_q.pclk |->
		(s_q.rd ? s_q.ad_oe_n : (!s_q.ad_oe_n && s_q.ad_o == s_q.wdat)))
		else $error("port direction wrong in second half");
	ram_lo_a: assert property (s_q.ram_lo_n == s_q.addr[A15])
		else $error("low RAM select wrong");
	ram_hi_a: assert property (s_q.ram_hi |-> s_q.addr[A14] && s_q.pclk)
		else $error("high RAM select outside its window");
	ram_window_a: assert property (!s_q.ram_lo_n && s_q.ram_hi |->
		s_q.addr >= RAM_BASE && s_q.addr <= RAM_TOP)
		else $error("RAM selected outside window");
	we_half_a: assert property ($fell(s_q.we_n) |-> s_q.pclk && !s_q.rd ##1 !s_q.we_n
		##1 s_q.we_n)
		else $error("write strobe not two second-half cycles");
	io_enable_a: assert property (s_q.sel_n != SEL_NONE |->
		s_q.pclk && !s_q.addr[A15] && !s_q.addr[A14])
		else $error("I/O select outside decoder window");
	io_range_a: assert property (s_q.sel_n != SEL_NONE |->
		s_q.sel_n == ~(SEL_ONE << s_q.addr[IO_IDX_MSB:IO_IDX_LSB]))
		else $error("wrong I/O select for address");
	switch_rd_a: assert property (s_q.ph == PH_DATA1 && s_q.act && s_q.rd &&
		!s_q.sel_n[IO_SWITCH_RD_A] |=> s_q.rdat == $past(ADDR_SWITCH_BITS[7:0]))
		else $error("switch read data wrong");
	id_rd_a: assert property (s_q.ph == PH_DATA1 && s_q.act && s_q.rd &&
		!s_q.sel_n[IO_ID_RD_B] |=>
		s_q.rdat == {$past(ADDR_SWITCH_BITS[9:8]), $past(BOARD_ID)})
		else $error("ID read data wrong");
	tx_quiet_a: assert property (!rst_done |-> ##1 !s_q.tx_en)
		else $error("transmit enabled during reset");

	addr_out_a: assert property (s_q.act && !s_q.pclk |->
		!s_q.ad_oe_n && s_q.ad_o == s_q.addr[7:0])
		else $error("low address not driven in first half");
	cyc_len_a: assert property ($rose(s_q.strobe) |=> !s_q.strobe ##1 !s_q.strobe
		##1 !s_q.strobe ##1 s_q.strobe)
		else $error("bus cycle not four clocks");
	ram_hi_on_a: assert property (s_q.act && s_q.pclk && s_q.addr[A14] |-> s_q.ram_hi)
		else $error("high RAM select missing");
	we_read_a: assert property (s_q.act && s_q.rd |-> s_q.we_n)
		else $error("write strobe in a read cycle");
	io_on_a: assert property (s_q.act && s_q.pclk && !s_q.addr[A15] && !s_q.addr[A14] |->
		s_q.sel_n != SEL_NONE)
		else $error("I/O select missing in decoder window");
	io_onehot_a: assert property (s_q.sel_n != SEL_NONE |-> $onehot(~s_q.sel_n))
		else $error("more than one I/O select active");
	ad_release_a: assert property (!s_q.act |-> s_q.ad_oe_n && s_q.we_n)
		else $error("port driven outside a bus cycle");

	// ************************************
	// Cover points
	// ************************************
	wr_cyc_c: cover property (s_q.act && !s_q.rd && !s_q.we_n);
	sw_rd_c: cover property (s_q.act && !s_q.sel_n[IO_SWITCH_RD_A]);
	ram_sel_c: cover property (!s_q.ram_lo_n && s_q.ram_hi);
	tx_on_c: cover property ($rose(s_q.tx_en));
endmodule
`default_nettype wire

// ===== verification/pcg_ext_model.sv
// Far-side model: static RAM and I/O devices on the external bus
`timescale 1ns/100ps
`default_nettype none
module pcg_ext_model (
	// Clock
	input  wire logic       clk,
	// Bus from the glue
	input  wire logic [7:0] addr_hi,
	input  wire logic [7:0] addr_lo,
	input  wire logic [7:0] ad_o,
	input  wire logic       ad_oe_n,
	input  wire logic       ext_rd,
	input  wire logic       ram_sel_lo_n,
	input  wire logic       ram_sel_hi,
	input  wire logic       ram_we_n,
	input  wire logic [7:0] io_sel_n,
	// Read data back to the glue
	output logic [7:0]      ad_i
);
	logic [7:0]  mem [0:8191];
	logic [7:0]  last_q;
	logic [12:0] ram_a;
	logic        ram_on;
	assign ram_a  = {addr_hi[4:0], addr_lo};
	assign ram_on = !ram_sel_lo_n && ram_sel_hi;
	always @(posedge clk) begin
		if (ram_on && !ram_we_n)
			mem[ram_a] <= ad_o;
		last_q <= ad_i;
	end
	// selected RAM or I/O 0-5 drive read data; otherwise return the inverse of the last value
	always_comb begin
		ad_i = ~last_q;
		if (ram_on && ext_rd && ad_oe_n)
			ad_i = mem[ram_a];
		for (int k = 0; k < 6; k++) begin
			if (!io_sel_n[k] && ext_rd && ad_oe_n)
				ad_i = 8'hA0 | 8'(k);
		end
	end
endmodule
`default_nettype wire

// ===== verification/tb_pcg_glue.sv
// Self-checking bench for the panel CPU bus glue
`timescale 1ns/100ps
`default_nettype none
`define CHK(g,e) begin n_tests++; if ((g)!==(e)) begin bad_count++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_pcg_glue;
	import pcg_pkg::*;
	localparam int unsigned HOLD = 20;
	logic        clk, rst_n, hsel, hwrite, supply_ok;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata;
	logic [9:0]  sw;
	logic [5:0]  id;
	wire logic        hready, hresp, oe_n, strobe, ext_rd, ph_clk, sel_lo_n, sel_hi;
	wire logic        we_n, ser_bit, ser_clk, tx_en, sys_rst_n;
	wire logic [31:0] hrdata;
	wire logic [7:0]  a_hi, a_lo, ad_i, ad_o, io_sel_n;
	wire logic [3:0]  lamp_sel_n;
	int          bad_count = 0, n_tests = 0, cyc = 0, glitch = 0, lamp_n = 0;
	logic [7:0]  sel_seen, lo_seen, dat_seen, lamp_sh;
	logic        ram_seen, hi_seen, ln_seen, we_seen, str_q, oe_q, act_q, sclk_q;
	pcg_glue #(.RST_HOLD_CYC(HOLD)) pcg_glue_i (
		.CLOCK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
		.HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp), .EXT_ADDR_HI(a_hi),
		.EXT_ADDR_LO(a_lo), .EXT_AD_I(ad_i), .EXT_AD_O(ad_o), .EXT_AD_OE_N(oe_n),
		.ADDR_STROBE(strobe), .EXT_RD(ext_rd), .BUS_PHASE_CLK(ph_clk),
		.RAM_SEL_LO_N(sel_lo_n), .RAM_SEL_HI(sel_hi), .RAM_WE_N(we_n), .IO_SEL_N(io_sel_n),
		.ADDR_SWITCH_BITS(sw), .BOARD_ID(id), .LAMP_SER_BIT(ser_bit),
		.LAMP_SER_CLK(ser_clk), .LAMP_DRV_SEL_N(lamp_sel_n), .LINE_TX_EN(tx_en),
		.SUPPLY_OK(supply_ok), .SYS_RST_N(sys_rst_n));
	pcg_ext_model pcg_ext_model_i (
		.clk(clk), .addr_hi(a_hi), .addr_lo(a_lo), .ad_o(ad_o), .ad_oe_n(oe_n),
		.ext_rd(ext_rd), .ram_sel_lo_n(sel_lo_n), .ram_sel_hi(sel_hi), .ram_we_n(we_n),
		.io_sel_n(io_sel_n), .ad_i(ad_i));
	// ************************************
	// Clock, timeout and pin monitors
	// ************************************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			report_and_stop;
		end
		if (ser_clk === 1'b1 && sclk_q === 1'b0) begin
			lamp_sh = {lamp_sh[6:0], ser_bit};
			lamp_n++;
		end
		sclk_q = ser_clk;
	end
	always @(negedge clk) begin
		if (strobe === 1'b1)
			act_q = 1'b0;
		if (strobe === 1'b0 && str_q === 1'b1 && oe_q === 1'b0) begin
			lo_seen = a_lo;
			act_q = 1'b1;
		end
		if (ph_clk === 1'b1) begin
			sel_seen &= io_sel_n;
			if (sel_hi === 1'b1) hi_seen = 1'b1;
			if (sel_hi === 1'b1 && sel_lo_n === 1'b0) ram_seen = 1'b1;
			if (we_n === 1'b0) begin
				we_seen = 1'b1;
				dat_seen = ad_o;
			end
			if (act_q === 1'b1) begin
				ln_seen = sel_lo_n;
				if (a_lo !== lo_seen) glitch++;
			end
		end else if (io_sel_n !== SEL_NONE || sel_hi !== 1'b0 || we_n !== 1'b1)
			glitch++;
		str_q = strobe;
		oe_q = oe_n;
	end
	// ************************************
	// Bus tasks
	// ************************************
	task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic ext_op(input logic w, input logic [15:0] a, input logic [7:0] d,
			output logic [7:0] r);
		logic [31:0] x;
		ahb(1'b1, 32'(REG_EXT_ADDR), {16'h0000, a}, x);
		sel_seen = SEL_NONE;
		{ram_seen, hi_seen, we_seen} = 3'h0;
		ln_seen = ~a[15];
		lo_seen = ~a[7:0];
		dat_seen = ~d;
		ahb(1'b1, 32'(w ? REG_EXT_WR : REG_EXT_RD), {24'h000000, d}, x);
		do ahb(1'b0, 32'(REG_STATUS), 32'h0, x); while (x[ST_EXT_BUSY] !== 1'b0);
		ahb(1'b0, 32'(REG_EXT_RD), 32'h0, x);
		r = x[7:0];
	endtask
	task automatic chk_op(input logic w, input logic [15:0] a, input logic [7:0] d,
			input logic cd);
		logic [7:0] r, es;
		es = (a[15:14] == 2'h0) ? ~(SEL_ONE << a[13:11]) : SEL_NONE;
		ext_op(w, a, d, r);
		`CHK(lo_seen, a[7:0])
		`CHK(sel_seen, es)
		`CHK(ln_seen, a[15])
		`CHK(hi_seen, a[14])
		`CHK(ram_seen, a[15:14] == 2'h1)
		`CHK(we_seen, w)
		if (w) `CHK(dat_seen, d)
		if (cd) `CHK(r, d)
	endtask
	task automatic wait_rst;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (sys_rst_n !== 1'b1 && n < 1000);
		`CHK(n inside {[HOLD + 1:HOLD + 3]}, 1'b1)
	endtask
	// ************************************
	// Scenarios
	// ************************************
	task automatic t_reset;
		logic [31:0] x;
		`CHK(tx_en, 1'b0)
		`CHK(sys_rst_n, 1'b0)
		rst_n <= 1'b1;
		ahb(1'b1, 32'(REG_CTRL), 32'h1, x);
		repeat (2) @(posedge clk);
		`CHK(tx_en, 1'b0)
		supply_ok <= 1'b1;
		wait_rst;
		repeat (2) @(posedge clk);
		`CHK(tx_en, 1'b0)
		ahb(1'b1, 32'(REG_CTRL), 32'h1, x);
		repeat (2) @(posedge clk);
		`CHK(tx_en, 1'b1)
		`CHK(RST_HOLD_CYC_DEF / E_DIV >= CPU_RST_E_CYC, 1'b1)
		$display("done t_reset");
	endtask
	task automatic t_phase;
		int r, s, h;
		logic p;
		{r, s, h} = '0;
		@(posedge clk);
		p = ph_clk;
		repeat (40) begin
			@(posedge clk);
			if (ph_clk === 1'b1 && p === 1'b0) r++;
			if (strobe === 1'b1) s++;
			if (ph_clk === 1'b1) h++;
			p = ph_clk;
		end
		`CHK(r, 10)
		`CHK(h, 20)
		`CHK(s, 10)
		$display("done t_phase");
	endtask
	task automatic t_io;
		logic [7:0] ed;
		for (int k = 0; k < 8; k++) begin
			ed = (k == 6) ? sw[7:0] : (k == 7) ? {sw[9:8], id} : 8'hA0 | 8'(k);
			chk_op(1'b0, 16'(k * 16'h0800 + 16'h07FF), ed, 1'b1);
		end
		chk_op(1'b1, 16'h1000, 8'h3C, 1'b0);
		$display("done t_io");
	endtask
	task automatic t_ram;
		chk_op(1'b1, 16'h4123, 8'h5A, 1'b0);
		chk_op(1'b0, 16'h6123, 8'h5A, 1'b1);
		chk_op(1'b1, 16'h7FFF, 8'hC3, 1'b0);
		chk_op(1'b0, 16'h5FFF, 8'hC3, 1'b1);
		chk_op(1'b0, 16'h8000, 8'h00, 1'b0);
		chk_op(1'b1, 16'hC000, 8'h81, 1'b0);
		$display("done t_ram");
	endtask
	task automatic t_lamp;
		logic [31:0] x;
		for (int k = 0; k < 4; k++) begin
			ahb(1'b1, 32'(REG_CTRL), 32'h10 << k, x);
			repeat (2) @(posedge clk);
			`CHK(lamp_sel_n, ~(4'h1 << k))
		end
		lamp_n = 0;
		ahb(1'b1, 32'(REG_LAMP), 32'hB4, x);
		do ahb(1'b0, 32'(REG_STATUS), 32'h0, x); while (x[ST_LAMP_BUSY] !== 1'b0);
		repeat (4) @(posedge clk);
		`CHK(lamp_n, 8)
		`CHK(lamp_sh, 8'hB4)
		$display("done t_lamp");
	endtask
	task automatic t_tx;
		logic [31:0] x;
		ahb(1'b1, 32'(REG_CTRL), 32'h1, x);
		repeat (2) @(posedge clk);
		`CHK(tx_en, 1'b1)
		ahb(1'b1, 32'(REG_CTRL), 32'h0, x);
		repeat (2) @(posedge clk);
		`CHK(tx_en, 1'b0)
		ahb(1'b1, 32'(REG_CTRL), 32'h1, x);
		supply_ok <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK(sys_rst_n, 1'b0)
		`CHK(tx_en, 1'b0)
		supply_ok <= 1'b1;
		wait_rst;
		`CHK(tx_en, 1'b0)
		ahb(1'b0, 32'(REG_STATUS), 32'h0, x);
		`CHK(x[ST_RST_DONE], 1'b1)
		ahb(1'b0, 32'h0000_0100, 32'h0, x);
		`CHK(x, 32'h0)
		`CHK(hresp, HRESP_OKAY)
		$display("done t_tx");
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		{rst_n, hsel, hwrite, supply_ok} = 4'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		sw = 10'h2C9;
		id = 6'h1B;
		repeat (12) @(posedge clk);
		t_reset;
		t_phase;
		t_io;
		t_ram;
		t_lamp;
		t_tx;
		`CHK(glitch, 0)
		report_and_stop;
	end
endmodule
`default_nettype wire
